// ==== pkg/otr_pkg.sv ====
package otr_pkg;

  localparam int PCLK_HZ   = 250_000_000;
  localparam int MFRAME_HZ = 2_000;
  localparam int FRAME_HZ  = 8_000;
  localparam int ETH25_HZ  = 25_000_000;
  localparam int ETH50_HZ  = 50_000_000;
  localparam int ETH62_HZ  = 62_500_000;
  localparam int ETH125_HZ = 125_000_000;

  // period in pclk cycles; all divide exactly at 250 MHz
  localparam int MFRAME_CYC = PCLK_HZ / MFRAME_HZ;
  localparam int FRAME_CYC  = PCLK_HZ / FRAME_HZ;
  localparam int ETH25_CYC  = PCLK_HZ / ETH25_HZ;
  localparam int ETH50_CYC  = PCLK_HZ / ETH50_HZ;
  localparam int ETH62_CYC  = PCLK_HZ / ETH62_HZ;
  localparam int ETH125_CYC = PCLK_HZ / ETH125_HZ;

  localparam int DIV_W = 17;

  localparam logic [7:0] RATE_CFG_OFS = 8'h00;
  localparam logic [7:0] OUT_CTL_OFS  = 8'h04;
  localparam logic [7:0] STATUS_OFS   = 8'h08;

  localparam int RATE_CODE_LSB   = 4;
  localparam int ETH_SEL_BIT     = 1;
  localparam int ETH_APLL_EN_BIT = 6;

  localparam logic [7:0] RATE_CFG_RST = 8'h80;
  localparam logic [7:0] OUT_CTL_RST  = 8'h00;

  // divisors applied to the multiplier ticks, per code
  localparam logic [4:0] MAIN_DIV_5 = 5'h01;
  localparam logic [4:0] MAIN_DIV_6 = 5'h02;
  localparam logic [4:0] MAIN_DIV_7 = 5'h03;
  localparam logic [4:0] MAIN_DIV_8 = 5'h04;
  localparam logic [4:0] MAIN_DIV_9 = 5'h06;
  localparam logic [4:0] MAIN_DIV_A = 5'h08;
  localparam logic [4:0] AUX_DIV_B  = 5'h01;
  localparam logic [4:0] AUX_DIV_C  = 5'h02;
  localparam logic [4:0] AUX_DIV_D  = 5'h10;
  localparam logic [4:0] AUX_DIV_E  = 5'h04;
  localparam logic [4:0] AUX_DIV_F  = 5'h08;

  typedef enum logic [2:0] {
    SRC_OFF, SRC_MFRAME, SRC_FRAME, SRC_DIG2, SRC_DIG1, SRC_MAIN, SRC_AUX, SRC_ETH
  } otr_src_t;

  typedef struct packed {
    otr_src_t   src;
    logic [4:0] div;
  } otr_route_t;

  function automatic otr_route_t otr_decode(input logic eth, input logic [3:0] code);
    otr_route_t r;
    r.src = SRC_OFF;
    r.div = 5'h01;
    if (eth) begin
      r.src = SRC_ETH;
    end else begin
      unique case (code)
        4'h0: r.src = SRC_OFF;
        4'h1: r.src = SRC_MFRAME;
        4'h2: r.src = SRC_FRAME;
        4'h3: r.src = SRC_DIG2;
        4'h4: r.src = SRC_DIG1;
        4'h5: begin r.src = SRC_MAIN; r.div = MAIN_DIV_5; end
        4'h6: begin r.src = SRC_MAIN; r.div = MAIN_DIV_6; end
        4'h7: begin r.src = SRC_MAIN; r.div = MAIN_DIV_7; end
        4'h8: begin r.src = SRC_MAIN; r.div = MAIN_DIV_8; end
        4'h9: begin r.src = SRC_MAIN; r.div = MAIN_DIV_9; end
        4'ha: begin r.src = SRC_MAIN; r.div = MAIN_DIV_A; end
        4'hb: begin r.src = SRC_AUX;  r.div = AUX_DIV_B;  end
        4'hc: begin r.src = SRC_AUX;  r.div = AUX_DIV_C;  end
        4'hd: begin r.src = SRC_AUX;  r.div = AUX_DIV_D;  end
        4'he: begin r.src = SRC_AUX;  r.div = AUX_DIV_E;  end
        4'hf: begin r.src = SRC_AUX;  r.div = AUX_DIV_F;  end
      endcase
    end
    return r;
  endfunction

  function automatic logic [DIV_W-1:0] otr_eth_div(input logic [1:0] sel);
    logic [DIV_W-1:0] d;
    d = DIV_W'(ETH25_CYC);
    unique case (sel)
      2'h0: d = DIV_W'(ETH25_CYC);
      2'h1: d = DIV_W'(ETH50_CYC);
      2'h2: d = DIV_W'(ETH62_CYC);
      2'h3: d = DIV_W'(ETH125_CYC);
    endcase
    return d;
  endfunction

endpackage

// ==== src/otr_tick_div.sv ====
`timescale 1ns/1ps
`default_nettype none
module otr_tick_div
  import otr_pkg::*;
#(
  parameter int W = DIV_W
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] divisor,
  output logic              tick_out
);

  // refused at elaboration: a one-bit count cannot divide
  if (W < 2) begin
    $error("otr_tick_div: W must be at least 2");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } otr_div_st_t;

  otr_div_st_t st_r;
  otr_div_st_t st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (tick_in) begin
      // a shrinking divisor must not strand the count above it
      if (st_r.cnt + W'(1) >= divisor) begin
        st_nxt.cnt  = '0;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_out = st_r.tick;

endmodule
`default_nettype wire

// ==== src/otr_out_stage.sv ====
`timescale 1ns/1ps
`default_nettype none
module otr_out_stage
  import otr_pkg::*;
(
  input  wire logic     pclk,
  input  wire logic     presetn,
  input  wire otr_src_t src,
  input  wire logic     eth_apll_on,
  input  wire logic     mframe_tick,
  input  wire logic     frame_tick,
  input  wire logic     dig2_tick,
  input  wire logic     dig1_tick,
  input  wire logic     main_tick,
  input  wire logic     aux_tick,
  input  wire logic     eth_tick,
  output logic          out_tick,
  output logic          out_enable
);

  typedef struct packed {
    logic tick;
    logic en;
  } otr_out_st_t;

  otr_out_st_t st_r;
  otr_out_st_t st_nxt;

  always_comb begin
    st_nxt.en   = 1'b1;
    st_nxt.tick = 1'b0;
    unique case (src)
      SRC_OFF:    st_nxt.en = 1'b0;
      SRC_MFRAME: st_nxt.tick = mframe_tick;
      SRC_FRAME:  st_nxt.tick = frame_tick;
      SRC_DIG2:   st_nxt.tick = dig2_tick;
      SRC_DIG1:   st_nxt.tick = dig1_tick;
      SRC_MAIN:   st_nxt.tick = main_tick;
      SRC_AUX:    st_nxt.tick = aux_tick;
      SRC_ETH: begin
        // no ethernet rate without its multiplier running
        st_nxt.en   = eth_apll_on;
        st_nxt.tick = eth_tick & eth_apll_on;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign out_tick   = st_r.tick;
  assign out_enable = st_r.en;

endmodule
`default_nettype wire

// ==== src/otr_rate_select.sv ====
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module otr_rate_select
  import otr_pkg::*;
#(
  parameter int MFRAME_DIV = MFRAME_CYC,
  parameter int FRAME_DIV  = FRAME_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        main_path_multiplier_tick,
  input  wire logic        auxiliary_path_multiplier_tick,
  input  wire logic        first_digital_generator_tick,
  input  wire logic        second_digital_generator_tick,
  output logic             second_output_tick,
  output logic             second_output_enable,
  output logic             eth_apll_enable
);

  // refused at elaboration: the dividers count in DIV_W bits
  if (MFRAME_DIV < 2 || MFRAME_DIV >= (1 << DIV_W)) begin
    $error("otr_rate_select: MFRAME_DIV out of range");
  end
  if (FRAME_DIV < 2 || FRAME_DIV >= (1 << DIV_W)) begin
    $error("otr_rate_select: FRAME_DIV out of range");
  end

  typedef struct packed {
    logic [7:0]  cfg;
    logic [7:0]  ctl;
    logic [31:0] rdata;
    logic        slverr;
  } otr_st_t;

  otr_st_t st_r;
  otr_st_t st_nxt;

  logic       setup;
  logic       access_wr;
  logic       hit;
  logic [3:0] code;
  logic       eth_sel;
  logic       eth_on;
  otr_route_t route;
  logic       mframe_tick;
  logic       frame_tick;
  logic       main_tick;
  logic       aux_tick;
  logic       eth_tick;
  logic       out_tick;
  logic       out_en;

  assign code    = st_r.cfg[RATE_CODE_LSB +: 4];
  assign eth_sel = st_r.ctl[ETH_SEL_BIT];
  assign eth_on  = st_r.ctl[ETH_APLL_EN_BIT];
  assign route   = otr_decode(eth_sel, code);

  assign setup     = psel & ~penable;
  assign access_wr = psel & penable & pwrite;
  assign hit       = (paddr == RATE_CFG_OFS) || (paddr == OUT_CTL_OFS)
                     || (paddr == STATUS_OFS);

  // read data and error are latched in setup so the access needs no wait
  always_comb begin
    st_nxt = st_r;
    if (setup) begin
      st_nxt.slverr = ~hit | (pwrite & (paddr == STATUS_OFS));
      st_nxt.rdata  = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          RATE_CFG_OFS: st_nxt.rdata = {24'h00_0000, st_r.cfg};
          OUT_CTL_OFS:  st_nxt.rdata = {24'h00_0000, st_r.ctl};
          STATUS_OFS:   st_nxt.rdata = {27'h000_0000, out_en, route.src, out_tick};
          default:      st_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end
    if (access_wr) begin
      if (paddr == RATE_CFG_OFS) begin
        st_nxt.cfg = pwdata[7:0];
      end
      if (paddr == OUT_CTL_OFS) begin
        st_nxt.ctl = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.cfg    <= RATE_CFG_RST;
      st_r.ctl    <= OUT_CTL_RST;
      st_r.rdata  <= 32'h0000_0000;
      st_r.slverr <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = st_r.rdata;
  assign pslverr = st_r.slverr & psel & penable;

  otr_tick_div u_mframe (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick_in  (1'b1),
    .divisor  (DIV_W'(MFRAME_DIV)),
    .tick_out (mframe_tick)
  );

  otr_tick_div u_frame (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick_in  (1'b1),
    .divisor  (DIV_W'(FRAME_DIV)),
    .tick_out (frame_tick)
  );

  otr_tick_div u_main (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick_in  (main_path_multiplier_tick),
    .divisor  ({{(DIV_W-5){1'b0}}, route.div}),
    .tick_out (main_tick)
  );

  otr_tick_div u_aux (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick_in  (auxiliary_path_multiplier_tick),
    .divisor  ({{(DIV_W-5){1'b0}}, route.div}),
    .tick_out (aux_tick)
  );

  // stalls while the ethernet multiplier is off
  otr_tick_div u_eth (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick_in  (eth_on),
    .divisor  (otr_eth_div(code[1:0])),
    .tick_out (eth_tick)
  );

  otr_out_stage u_out (
    .pclk        (pclk),
    .presetn     (presetn),
    .src         (route.src),
    .eth_apll_on (eth_on),
    .mframe_tick (mframe_tick),
    .frame_tick  (frame_tick),
    .dig2_tick   (second_digital_generator_tick),
    .dig1_tick   (first_digital_generator_tick),
    .main_tick   (main_tick),
    .aux_tick    (aux_tick),
    .eth_tick    (eth_tick),
    .out_tick    (out_tick),
    .out_enable  (out_en)
  );

  assign second_output_tick   = out_tick;
  assign second_output_enable = out_en;
  assign eth_apll_enable      = eth_on;

endmodule
`default_nettype wire

// ==== test/otr_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module otr_chk
  import otr_pkg::*;
#(
  parameter int MFRAME_DIV = 20,
  parameter int FRAME_DIV  = 8
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        main_path_multiplier_tick,
  input wire logic        auxiliary_path_multiplier_tick,
  input wire logic        second_output_tick,
  input wire logic        second_output_enable,
  input wire logic        eth_apll_enable
);
  logic [3:0]  code_r;
  logic        eth_r;
  logic        apll_r;
  logic [15:0] calm_r;
  logic [15:0] gap_r;
  logic [15:0] in_r;
  logic [15:0] per;
  logic [15:0] div;
  logic        wr;
  logic        src_in;
  logic        calm;
  assign wr = psel && penable && pwrite;
  assign src_in = code_r > 4'ha ? auxiliary_path_multiplier_tick : main_path_multiplier_tick;
  // margin covers the early first tick after a change
  assign calm = calm_r > gap_r + 16'h0004;
  always_comb begin
    per = 16'h0000;
    div = 16'h0000;
    if (eth_r && apll_r) begin
      case (code_r[1:0])
        2'h0: per = 16'h000a;
        2'h1: per = 16'h0005;
        2'h2: per = 16'h0004;
        default: per = 16'h0002;
      endcase
    end else if (!eth_r) begin
      case (code_r)
        4'h1: per = 16'(MFRAME_DIV);
        4'h2: per = 16'(FRAME_DIV);
        4'h5, 4'hb: div = 16'h0001;
        4'h6, 4'hc: div = 16'h0002;
        4'h7: div = 16'h0003;
        4'h8, 4'he: div = 16'h0004;
        4'h9: div = 16'h0006;
        4'ha, 4'hf: div = 16'h0008;
        4'hd: div = 16'h0010;
        default: ;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_r <= RATE_CFG_RST[7:4];
      eth_r  <= 1'b0;
      apll_r <= 1'b0;
      calm_r <= 16'h0000;
      gap_r  <= 16'h0000;
      in_r   <= 16'h0000;
    end else begin
      if (wr && paddr == RATE_CFG_OFS) code_r <= pwdata[7:4];
      if (wr && paddr == OUT_CTL_OFS) begin
        eth_r  <= pwdata[ETH_SEL_BIT];
        apll_r <= pwdata[ETH_APLL_EN_BIT];
      end
      calm_r <= wr ? 16'h0000 : calm_r + 16'(calm_r != 16'hffff);
      gap_r  <= second_output_tick ? 16'h0001 : gap_r + 16'(gap_r != 16'hffff);
      in_r   <= (second_output_tick ? 16'h0000 : in_r) + 16'(src_in);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_off;
    (!eth_r && code_r == 4'h0)[*3];
  endsequence
  sequence s_fast;
    (eth_r && apll_r && code_r[1:0] == 2'h3)[*8];
  endsequence
  property p_off;
    s_off |-> !second_output_enable && !second_output_tick;
  endproperty
  property p_live;
    (!eth_r && code_r != 4'h0)[*3] |-> second_output_enable;
  endproperty
  property p_gate;
    (eth_r && !apll_r)[*4] |-> !second_output_enable && !second_output_tick;
  endproperty
  property p_eth_on;
    (eth_r && apll_r)[*3] |-> second_output_enable;
  endproperty
  property p_apll;
    eth_apll_enable == apll_r;
  endproperty
  property p_period;
    second_output_tick && calm && per != 16'h0000 |-> gap_r == per;
  endproperty
  property p_div;
    second_output_tick && calm && div != 16'h0000 |-> in_r == div;
  endproperty
  property p_fast;
    s_fast ##0 second_output_tick |=> !second_output_tick ##1 second_output_tick;
  endproperty
  a_off: assert property (p_off) else $error("output live while off");
  a_live: assert property (p_live) else $error("output not enabled");
  a_gate: assert property (p_gate) else $error("eth rate without multiplier");
  a_eth_on: assert property (p_eth_on) else $error("eth rate not enabled");
  a_apll: assert property (p_apll) else $error("eth multiplier enable wrong");
  a_period: assert property (p_period) else $error("tick period wrong");
  a_div: assert property (p_div) else $error("divide ratio wrong");
  a_fast: assert property (p_fast) else $error("125 MHz pattern wrong");
endmodule
bind otr_rate_select otr_chk #(.MFRAME_DIV(MFRAME_DIV), .FRAME_DIV(FRAME_DIV)) u_chk (
  .pclk                           (pclk),
  .presetn                        (presetn),
  .psel                           (psel),
  .penable                        (penable),
  .pwrite                         (pwrite),
  .paddr                          (paddr),
  .pwdata                         (pwdata),
  .main_path_multiplier_tick      (main_path_multiplier_tick),
  .auxiliary_path_multiplier_tick (auxiliary_path_multiplier_tick),
  .second_output_tick             (second_output_tick),
  .second_output_enable           (second_output_enable),
  .eth_apll_enable                (eth_apll_enable)
);
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import otr_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        er;
  logic        main_path_multiplier_tick = 1'b1;
  logic        auxiliary_path_multiplier_tick = 1'b0;
  logic        first_digital_generator_tick = 1'b0;
  logic        second_digital_generator_tick = 1'b0;
  logic        second_output_tick;
  logic        second_output_enable;
  logic        eth_apll_enable;
  int          cnt = 0;
  int          per;
  int          n_fail = 0;
  int          checked = 0;
  // auxiliary input ticks every other cycle, so its periods are twice the divisor
  int          exp_per [16] = '{0, 20, 8, 3, 7, 1, 2, 3, 4, 6, 8, 2, 4, 32, 8, 16};
  int          eth_per [4] = '{10, 5, 4, 2};
  otr_rate_select #(.MFRAME_DIV(20), .FRAME_DIV(8)) dut (
    .pclk                           (pclk),
    .presetn                        (presetn),
    .psel                           (psel),
    .penable                        (penable),
    .pwrite                         (pwrite),
    .paddr                          (paddr),
    .pwdata                         (pwdata),
    .prdata                         (prdata),
    .pready                         (pready),
    .pslverr                        (pslverr),
    .main_path_multiplier_tick      (main_path_multiplier_tick),
    .auxiliary_path_multiplier_tick (auxiliary_path_multiplier_tick),
    .first_digital_generator_tick   (first_digital_generator_tick),
    .second_digital_generator_tick  (second_digital_generator_tick),
    .second_output_tick             (second_output_tick),
    .second_output_enable           (second_output_enable),
    .eth_apll_enable                (eth_apll_enable)
  );
  initial forever #2 pclk = ~pclk;
  // generators at coprime rates so the two codes are told apart;
  // main and auxiliary at different rates so a swapped route shows
  always @(posedge pclk) begin
    cnt <= cnt + 1;
    auxiliary_path_multiplier_tick <= (cnt % 2 == 0);
    second_digital_generator_tick <= (cnt % 3 == 0);
    first_digital_generator_tick <= (cnt % 7 == 0);
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // third gap skips any early tick after a change
  task automatic meas();
    repeat (3) begin
      per = 0;
      do begin
        @(posedge pclk);
        per++;
      end while (second_output_tick !== 1'b1 && per < 100);
    end
  endtask
  task automatic t_reset();
    apb(1'b0, RATE_CFG_OFS, 32'h0);
    chk(rd, 32'h80, "rate cfg reset");
    apb(1'b0, OUT_CTL_OFS, 32'h0);
    chk(rd, 32'h0, "out ctl reset");
    chk(second_output_enable, 1'b1, "enable at reset");
    chk(eth_apll_enable, 1'b0, "apll at reset");
    $display("reset test done");
  endtask
  task automatic t_codes();
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, RATE_CFG_OFS, {24'h0, 4'(c), 4'h0});
      apb(1'b0, RATE_CFG_OFS, 32'h0);
      chk(rd, {24'h0, 4'(c), 4'h0}, "rate cfg");
      repeat (4) @(posedge pclk);
      chk(second_output_enable, 1'(c != 0), "enable");
      if (c != 0) begin
        meas();
        chk(per, exp_per[c], "period");
      end
    end
    $display("code test done");
  endtask
  task automatic t_eth();
    apb(1'b1, OUT_CTL_OFS, 32'h2);
    repeat (4) @(posedge pclk);
    chk(second_output_enable, 1'b0, "eth gated");
    apb(1'b1, OUT_CTL_OFS, 32'h42);
    // the write lands at the edge apb returns on; look once it is registered
    repeat (2) @(posedge pclk);
    chk(eth_apll_enable, 1'b1, "apll on");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, RATE_CFG_OFS, {24'h0, 2'h2, 2'(i), 4'h0});
      repeat (10) @(posedge pclk);
      meas();
      chk(per, eth_per[i], "eth period");
    end
    apb(1'b1, OUT_CTL_OFS, 32'h0);
    $display("eth test done");
  endtask
  task automatic t_err();
    apb(1'b0, 8'h0c, 32'h0);
    chk(er, 1'b1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    apb(1'b1, STATUS_OFS, 32'h0);
    chk(er, 1'b1, "status write error");
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(er, 1'b0, "status read error");
    // code 1011 left by the ethernet test: auxiliary source, output enabled
    chk(rd & 32'hffff_fffe, 32'h1c, "status source");
    $display("error test done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_codes();
    t_eth();
    t_err();
    final_report();
  end
endmodule
`default_nettype wire
